// ---- common/core_map_defs.svh ----
`ifndef CORE_MAP_DEFS_SVH
`define CORE_MAP_DEFS_SVH
`define SP_RESET 8'h07
`define FETCH_RESET 16'h0000
`define PSW_RESET 8'h00
`define DP_RESET 16'h0000
`define PSW_CY 7
`define PSW_AC 6
`define PSW_F0 5
`define PSW_RS_HI 4
`define PSW_RS_LO 3
`define PSW_OV 2
`define PSW_P 0
`define VEC_EXT0 16'h0003
`define VEC_TMR0 16'h000b
`define VEC_EXT1 16'h0013
`define VEC_TMR1 16'h001b
`define BIT_AREA_BASE 8'h20
`define SFR_BASE 8'h80
`define AUX_RAM_HI 8'hff
`define SFR_ACC 8'he0
`define SFR_B 8'hf0
`define SFR_SP 8'h81
`define SFR_DPL 8'h82
`define SFR_DPH 8'h83
`define SFR_PSW 8'hd0
`define SFR_AUX_IDX 8'h94
`define SFR_AUX_PORT 8'h95
`endif

// ---- common/core_map_pkg.sv ----
package core_map_pkg;
  typedef enum logic [2:0] {
    op_none, op_alu, op_push, op_pop, op_call, op_ret, op_irq, op_load_pc
  } op_type;
  typedef enum logic [1:0] {
    alu_add, alu_sub, alu_rot, alu_clear_overflow_op
  } alu_type;
  typedef struct packed {
    logic [7:0] acc;
    logic [7:0] helper;
    logic [7:0] sp;
    logic [7:0] program_status_word;
    logic [15:0] fetch;
    logic [15:0] data_pointer;
    logic [7:0] aux_idx;
    logic [7:0] rd_data;
    logic [7:0] xd_data;
    logic [7:0] mem_addr;
  } state_type;
endpackage

// ---- src/core_reg_map.sv ----
`include "core_map_defs.svh"
module core_reg_map #(
  parameter int ram_depth = 256,
  parameter int aux_depth = 256
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire core_map_pkg::op_type op,
  input wire core_map_pkg::alu_type alu_op,
  input wire logic [7:0] alu_operand,
  input wire logic alu_use_carry,
  input wire logic rot_left,
  input wire logic [15:0] load_pc,
  input wire logic [1:0] irq_sel,
  input wire logic bit_test,
  input wire logic [7:0] bit_test_operand,
  input wire logic mul_div_wr,
  input wire logic [15:0] mul_div_pair,
  input wire logic dir_wr,
  input wire logic dir_rd,
  input wire logic [7:0] dir_addr,
  input wire logic [7:0] dir_wdata,
  input wire logic ind_wr,
  input wire logic ind_rd,
  input wire logic [7:0] ind_addr,
  input wire logic [7:0] ind_wdata,
  input wire logic bank_wr,
  input wire logic [2:0] bank_reg,
  input wire logic [7:0] bank_wdata,
  input wire logic bit_wr,
  input wire logic [7:0] bit_addr,
  input wire logic bit_val,
  input wire logic xd_wr,
  input wire logic xd_rd,
  input wire logic xd_use_data_pointer,
  input wire logic [7:0] xd_index,
  input wire logic [7:0] xd_wdata,
  input wire logic aux_enable,
  output logic [7:0] rd_data,
  output logic [7:0] xd_rdata,
  output logic [15:0] fetch_counter,
  output logic [7:0] stack_ptr_reg,
  output logic [7:0] core_status_word,
  output logic [15:0] xdata_pointer,
  output logic [15:0] acc_pair,
  output logic [7:0] mem_addr
);
  core_map_pkg::state_type s_q, s_d;
  logic [7:0] iram [ram_depth];
  logic [7:0] aux_ram_256 [aux_depth];
  logic [7:0] bank_addr;
  logic [15:0] xd_addr;
  logic aux_hit;
  logic [7:0] push_addr;
  logic [8:0] sum9;
  logic [4:0] sum5;
  logic [7:0] res;
  logic ovf;
  logic [7:0] bit_byte;

  // Register operands only ever reach the bank that the status word selects.
  function automatic logic [7:0] bank_map(input logic [7:0] program_status_word, input logic [2:0] r);
    bank_map = {3'h0, program_status_word[`PSW_RS_HI], program_status_word[`PSW_RS_LO], r};
  endfunction

  // Unknown special addresses read as zero rather than aliasing the upper RAM.
  function automatic logic [7:0] sfr_read(input core_map_pkg::state_type s, input logic [7:0] a);
    case (a)
      `SFR_ACC: sfr_read = s.acc;
      `SFR_B: sfr_read = s.helper;
      `SFR_SP: sfr_read = s.sp;
      `SFR_DPL: sfr_read = s.data_pointer[7:0];
      `SFR_DPH: sfr_read = s.data_pointer[15:8];
      `SFR_PSW: sfr_read = s.program_status_word;
      `SFR_AUX_IDX: sfr_read = s.aux_idx;
      default: sfr_read = 8'h00;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  assign bank_addr = bank_map(s_q.program_status_word, bank_reg);
  // The pointer wraps through 00h, so the whole RAM can hold stack.
  assign push_addr = s_q.sp + 8'h01;
  assign xd_addr = xd_use_data_pointer ? s_q.data_pointer : {`AUX_RAM_HI, xd_index};
  assign aux_hit = aux_enable && (xd_addr[15:8] == `AUX_RAM_HI);
  // Bit addresses below 80h land in the bit area; above they address x0h/x8h registers.
  assign bit_byte = bit_addr[7] ? {bit_addr[7:3], 3'h0} : `BIT_AREA_BASE + {3'h0, bit_addr[6:2] >> 1};

  // A subtract leaves carry and nibble carry set when no borrow occurred.
  // Software chaining subtracts must therefore read the carry as not-borrow.
  always_comb begin
    sum9 = 9'h000;
    sum5 = 5'h00;
    res = s_q.acc;
    ovf = 1'b0;
    if (alu_op == core_map_pkg::alu_sub) begin
      sum9 = {1'b0, s_q.acc} - {1'b0, alu_operand} - {8'h00, alu_use_carry & s_q.program_status_word[`PSW_CY]};
      sum5 = {1'b0, s_q.acc[3:0]} - {1'b0, alu_operand[3:0]} - {4'h0, alu_use_carry & s_q.program_status_word[`PSW_CY]};
      res = sum9[7:0];
      ovf = (s_q.acc[7] != alu_operand[7]) && (res[7] != s_q.acc[7]);
    end else begin
      sum9 = {1'b0, s_q.acc} + {1'b0, alu_operand} + {8'h00, alu_use_carry & s_q.program_status_word[`PSW_CY]};
      sum5 = {1'b0, s_q.acc[3:0]} + {1'b0, alu_operand[3:0]} + {4'h0, alu_use_carry & s_q.program_status_word[`PSW_CY]};
      res = sum9[7:0];
      ovf = (s_q.acc[7] == alu_operand[7]) && (res[7] != s_q.acc[7]);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    s_d = s_q;
    s_d.rd_data = 8'h00;
    s_d.mem_addr = s_q.mem_addr;
    // Stack operations pre-increment, so the pointer always names the last byte written.
    case (op)
      core_map_pkg::op_alu: begin
        case (alu_op)
          core_map_pkg::alu_add: begin
            s_d.acc = res;
            s_d.program_status_word[`PSW_CY] = sum9[8];
            s_d.program_status_word[`PSW_AC] = sum5[4];
            s_d.program_status_word[`PSW_OV] = ovf;
          end
          core_map_pkg::alu_sub: begin
            s_d.acc = res;
            s_d.program_status_word[`PSW_CY] = ~sum9[8];
            s_d.program_status_word[`PSW_AC] = ~sum5[4];
            s_d.program_status_word[`PSW_OV] = ovf;
          end
          core_map_pkg::alu_rot: begin
            if (rot_left) begin
              s_d.acc = {s_q.acc[6:0], s_q.program_status_word[`PSW_CY]};
              s_d.program_status_word[`PSW_CY] = s_q.acc[7];
            end else begin
              s_d.acc = {s_q.program_status_word[`PSW_CY], s_q.acc[7:1]};
              s_d.program_status_word[`PSW_CY] = s_q.acc[0];
            end
          end
          core_map_pkg::alu_clear_overflow_op: s_d.program_status_word[`PSW_OV] = 1'b0;
          default: s_d.acc = s_q.acc;
        endcase
      end
      core_map_pkg::op_push: begin
        s_d.sp = push_addr;
        s_d.mem_addr = push_addr;
      end
      // The return address is pushed; the target only reloads the fetch counter.
      core_map_pkg::op_call: begin
        s_d.sp = s_q.sp + 8'h02;
        s_d.mem_addr = push_addr;
        s_d.fetch = load_pc;
      end
      core_map_pkg::op_irq: begin
        s_d.sp = s_q.sp + 8'h02;
        s_d.mem_addr = push_addr;
        case (irq_sel)
          2'd0: s_d.fetch = `VEC_EXT0;
          2'd1: s_d.fetch = `VEC_TMR0;
          2'd2: s_d.fetch = `VEC_EXT1;
          default: s_d.fetch = `VEC_TMR1;
        endcase
      end
      core_map_pkg::op_pop: begin
        s_d.rd_data = iram[s_q.sp];
        s_d.mem_addr = s_q.sp;
        s_d.sp = s_q.sp - 8'h01;
      end
      // Return takes the high byte from the top, mirroring the order a call pushed it.
      core_map_pkg::op_ret: begin
        s_d.sp = s_q.sp - 8'h02;
        s_d.fetch = {iram[s_q.sp], iram[s_q.sp - 8'h01]};
      end
      core_map_pkg::op_load_pc: s_d.fetch = load_pc;
      default: s_d.sp = s_q.sp;
    endcase
    // The flag sources below are ordered so that later ones win within one cycle.
    if (bit_test) begin
      s_d.program_status_word[`PSW_OV] = bit_test_operand[6];
    end
    if (mul_div_wr) begin
      {s_d.helper, s_d.acc} = mul_div_pair;
    end
    // Direct writes follow the operation so software can overwrite a flag just set.
    // Special space is reached only by direct and bit accesses; indirect accesses always go to RAM.
    if (dir_wr && dir_addr[7]) begin
      case (dir_addr)
        `SFR_ACC: s_d.acc = dir_wdata;
        `SFR_B: s_d.helper = dir_wdata;
        `SFR_SP: s_d.sp = dir_wdata;
        `SFR_DPL: s_d.data_pointer[7:0] = dir_wdata;
        `SFR_DPH: s_d.data_pointer[15:8] = dir_wdata;
        `SFR_PSW: s_d.program_status_word = dir_wdata;
        `SFR_AUX_IDX: s_d.aux_idx = dir_wdata;
        `SFR_AUX_PORT: s_d.aux_idx = s_q.aux_idx + 8'h01;
        default: s_d.aux_idx = s_d.aux_idx;
      endcase
    end
    if (dir_rd) begin
      if (dir_addr[7]) begin
        s_d.rd_data = (dir_addr == `SFR_AUX_PORT) ? aux_ram_256[s_q.aux_idx] : sfr_read(s_q, dir_addr);
        if (dir_addr == `SFR_AUX_PORT) begin
          s_d.aux_idx = s_q.aux_idx + 8'h01;
        end
      end else begin
        s_d.rd_data = iram[dir_addr];
      end
    end
    if (ind_rd) begin
      s_d.rd_data = iram[ind_addr];
    end
    if (bit_wr && bit_addr[7]) begin
      case (bit_byte)
        `SFR_ACC: s_d.acc[bit_addr[2:0]] = bit_val;
        `SFR_B: s_d.helper[bit_addr[2:0]] = bit_val;
        `SFR_PSW: s_d.program_status_word[bit_addr[2:0]] = bit_val;
        default: s_d.program_status_word = s_d.program_status_word;
      endcase
    end
    // Parity is recomputed last so a direct write to the status word cannot leave it stale.
    s_d.program_status_word[`PSW_P] = ^s_d.acc;
    // A read outside the window, or with the window disabled, returns zero.
    if (xd_rd && aux_hit) begin
      s_d.xd_data = aux_ram_256[xd_addr[7:0]];
    end else begin
      s_d.xd_data = 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Memories carry no reset; software must initialise them.
  always_ff @(posedge clk) begin
    if ((op == core_map_pkg::op_push) || ((op == core_map_pkg::op_call || op == core_map_pkg::op_irq))) begin
      iram[push_addr] <= (op == core_map_pkg::op_push) ? dir_wdata : s_q.fetch[7:0];
    end
    if (op == core_map_pkg::op_call || op == core_map_pkg::op_irq) begin
      iram[s_q.sp + 8'h02] <= s_q.fetch[15:8];
    end
    if (dir_wr && !dir_addr[7]) begin
      iram[dir_addr] <= dir_wdata;
    end
    if (ind_wr) begin
      iram[ind_addr] <= ind_wdata;
    end
    if (bank_wr) begin
      iram[bank_addr] <= bank_wdata;
    end
    if (bit_wr && !bit_addr[7]) begin
      iram[bit_byte][bit_addr[2:0]] <= bit_val;
    end
    if (xd_wr && aux_hit) begin
      aux_ram_256[xd_addr[7:0]] <= xd_wdata;
    end
    // Writes through the port use the index before it steps, matching the read side.
    if (dir_wr && dir_addr == `SFR_AUX_PORT) begin
      aux_ram_256[s_q.aux_idx] <= dir_wdata;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_q <= '0;
      s_q.sp <= `SP_RESET;
      s_q.fetch <= `FETCH_RESET;
      s_q.program_status_word <= `PSW_RESET;
      s_q.data_pointer <= `DP_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs come straight from the state register so no decode glitch reaches them.
  assign rd_data = s_q.rd_data;
  assign xd_rdata = s_q.xd_data;
  assign fetch_counter = s_q.fetch;
  assign stack_ptr_reg = s_q.sp;
  assign core_status_word = s_q.program_status_word;
  assign xdata_pointer = s_q.data_pointer;
  assign acc_pair = {s_q.helper, s_q.acc};
  assign mem_addr = s_q.mem_addr;
endmodule

// ---- verification/core_reg_map_asserts.sv ----
module core_reg_map_asserts (
  input wire logic clk,
  input wire logic reset_n,
  input wire core_map_pkg::op_type op,
  input wire core_map_pkg::alu_type alu_op,
  input wire logic [15:0] load_pc,
  input wire logic [1:0] irq_sel,
  input wire logic bit_test,
  input wire logic [7:0] bit_test_operand,
  input wire logic mul_div_wr,
  input wire logic [15:0] mul_div_pair,
  input wire logic dir_wr,
  input wire logic bit_wr,
  input wire logic xd_rd,
  input wire logic aux_enable,
  input wire logic [7:0] xd_rdata,
  input wire logic [15:0] fetch_counter,
  input wire logic [7:0] stack_ptr_reg,
  input wire logic [7:0] core_status_word,
  input wire logic [15:0] acc_pair,
  input wire logic [7:0] mem_addr
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // Direct writes are excluded because they win over the operation in the same cycle.
  AST_PUSH: assert property (op == core_map_pkg::op_push && !dir_wr |=>
    stack_ptr_reg == $past(stack_ptr_reg) + 8'h01 && mem_addr == stack_ptr_reg) else $error("push step wrong");
  AST_CALL: assert property (op == core_map_pkg::op_call && !dir_wr |=>
    stack_ptr_reg == $past(stack_ptr_reg) + 8'h02 && fetch_counter == $past(load_pc)) else $error("call wrong");
  AST_RET: assert property (op == core_map_pkg::op_ret && !dir_wr |=>
    stack_ptr_reg == $past(stack_ptr_reg) - 8'h02) else $error("return step wrong");
  AST_VECTOR: assert property (op == core_map_pkg::op_irq |=>
    fetch_counter == 16'h0003 + {$past(irq_sel), 3'b000}) else $error("vector wrong");
  AST_PARITY: assert property (core_status_word[0] == ^acc_pair[7:0]) else $error("parity wrong");
  AST_PAIR: assert property (mul_div_wr && !dir_wr && !bit_wr |=> acc_pair == $past(mul_div_pair))
    else $error("pair load wrong");
  AST_BIT_TEST: assert property (bit_test && !dir_wr && !bit_wr && op == core_map_pkg::op_none |=>
    core_status_word[2] == $past(bit_test_operand[6])) else $error("bit test wrong");
  AST_CLEAR_OV: assert property (op == core_map_pkg::op_alu && alu_op == core_map_pkg::alu_clear_overflow_op &&
    !bit_test && !dir_wr && !bit_wr |=> !core_status_word[2]) else $error("overflow not cleared");
  AST_AUX_OFF: assert property (xd_rd && !aux_enable |=> xd_rdata == 8'h00) else $error("aux decoded");
  cover property (op == core_map_pkg::op_call);
  cover property (op == core_map_pkg::op_irq && irq_sel == 2'h3);
  cover property (xd_rd && !aux_enable);
  cover property (op == core_map_pkg::op_alu && alu_op == core_map_pkg::alu_sub);
endmodule
bind core_reg_map core_reg_map_asserts core_reg_map_asserts_inst (.*);

// ---- verification/aux_ram_partner.sv ----
module aux_ram_partner (
  input wire logic clk,
  input wire logic xd_wr,
  input wire logic xd_use_data_pointer,
  input wire logic aux_enable,
  input wire logic [7:0] xd_index,
  input wire logic [15:0] xdata_pointer,
  input wire logic [7:0] xd_wdata,
  output logic [7:0] aux_expect
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [256];
  logic [15:0] addr;
  assign addr = xd_use_data_pointer ? xdata_pointer : {8'hff, xd_index};
  assign aux_expect = (aux_enable && addr[15:8] == 8'hff) ? mem[addr[7:0]] : 8'h00;
  always @(posedge clk) if (xd_wr && aux_enable && addr[15:8] == 8'hff) mem[addr[7:0]] <= xd_wdata;
endmodule

// ---- verification/testbench.sv ----
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  core_map_pkg::op_type op;
  core_map_pkg::alu_type alu_op;
  logic clk = 1'b0;
  logic reset_n, alu_use_carry, rot_left, bit_test, mul_div_wr, dir_wr, dir_rd, ind_wr, ind_rd, bank_wr, bit_wr;
  logic bit_val, xd_wr, xd_rd, xd_use_data_pointer, aux_enable;
  logic [7:0] alu_operand, bit_test_operand, dir_addr, dir_wdata, ind_addr, ind_wdata, bank_wdata, bit_addr;
  logic [7:0] xd_index, xd_wdata, rd_data, xd_rdata, stack_ptr_reg, core_status_word, mem_addr, aux_expect;
  logic [15:0] load_pc, mul_div_pair, fetch_counter, xdata_pointer, acc_pair;
  logic [1:0] irq_sel;
  logic [2:0] bank_reg;
  int n_errors = 0;
  int num_checks = 0;
  core_reg_map core_reg_map_inst (.*);
  aux_ram_partner aux_ram_partner_inst (.*);
  always #2.5 clk = ~clk;
  ////////////////////////////////////////////////////////////
  // Strobes drop one cycle after being raised, so no request is ever taken twice.
  // Each request first lets an idle edge pass, so no strobe falls and rises in one time step.
  task automatic step;
    @(negedge clk);
    op = core_map_pkg::op_none;
    {dir_wr, dir_rd, ind_wr, ind_rd, bank_wr, bit_wr, xd_wr, xd_rd, bit_test, mul_div_wr} = '0;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic dwr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    dir_wr = 1'b1; dir_addr = a; dir_wdata = d; step;
  endtask
  task automatic drd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk);
    dir_rd = 1'b1; dir_addr = a; step; chk(rd_data, e);
  endtask
  task automatic do_op(input core_map_pkg::op_type o);
    @(negedge clk);
    op = o; step;
  endtask
  task automatic alu(input core_map_pkg::alu_type f, input logic [7:0] v);
    @(negedge clk);
    op = core_map_pkg::op_alu; alu_op = f; alu_operand = v; step;
  endtask
  ////////////////////////////////////////////////////////////
  task automatic t_reset;
    chk(stack_ptr_reg, 16'h0007);
    chk(fetch_counter, 16'h0000);
    chk({core_status_word, 8'h00} | xdata_pointer, 16'h0000);
  endtask
  task automatic t_stack;
    dir_wdata = 8'h11; do_op(core_map_pkg::op_push);
    chk(mem_addr, 16'h0008);
    drd(8'h08, 8'h11);
    dwr(8'h81, 8'hff);
    dir_wdata = 8'h22; do_op(core_map_pkg::op_push);
    chk(stack_ptr_reg, 16'h0000);
    drd(8'h00, 8'h22);
    load_pc = 16'h1234; do_op(core_map_pkg::op_load_pc);
    chk(fetch_counter, 16'h1234);
    load_pc = 16'h5678; do_op(core_map_pkg::op_call);
    chk(fetch_counter, 16'h5678);
    chk(stack_ptr_reg, 16'h0002);
    drd(8'h01, 8'h34);
    drd(8'h02, 8'h12);
    do_op(core_map_pkg::op_ret);
    chk(fetch_counter, 16'h1234);
    chk(stack_ptr_reg, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      irq_sel = i[1:0]; do_op(core_map_pkg::op_irq);
      chk(fetch_counter, 16'h0003 + 16'(i * 8));
    end
  endtask
  task automatic t_alu;
    dwr(8'he0, 8'h7f);
    alu(core_map_pkg::alu_add, 8'h01);
    chk({acc_pair[7:0], core_status_word}, 16'h8045);
    alu(core_map_pkg::alu_add, 8'h80);
    chk({acc_pair[7:0], core_status_word}, 16'h0084);
    rot_left = 1'b1; alu(core_map_pkg::alu_rot, 8'h00);
    chk({acc_pair[7:0], core_status_word}, 16'h0105);
    alu(core_map_pkg::alu_clear_overflow_op, 8'h00);
    chk(core_status_word, 16'h0001);
    @(negedge clk);
    bit_test = 1'b1; bit_test_operand = 8'h40; step;
    chk(core_status_word, 16'h0005);
    @(negedge clk);
    mul_div_wr = 1'b1; mul_div_pair = 16'hbeef; step;
    chk(acc_pair, 16'hbeef);
    chk(core_status_word, 16'h0005);
    alu(core_map_pkg::alu_sub, 8'h10);
    chk({acc_pair[7:0], core_status_word}, 16'hdfc1);
    alu_use_carry = 1'b1; alu(core_map_pkg::alu_sub, 8'h0f);
    chk({acc_pair[7:0], core_status_word}, 16'hcf80);
    alu_use_carry = 1'b0; rot_left = 1'b0; alu(core_map_pkg::alu_rot, 8'h00);
    chk({acc_pair[7:0], core_status_word}, 16'he780);
  endtask
  task automatic t_space;
    logic [7:0] s;
    dwr(8'hd0, 8'h18);
    @(negedge clk);
    bank_wr = 1'b1; bank_reg = 3'h2; bank_wdata = 8'h5a; step;
    drd(8'h1a, 8'h5a);
    dwr(8'h2f, 8'h00);
    @(negedge clk);
    bit_wr = 1'b1; bit_addr = 8'h7f; bit_val = 1'b1; step;
    drd(8'h2f, 8'h80);
    s = stack_ptr_reg;
    @(negedge clk);
    ind_wr = 1'b1; ind_addr = 8'h81; ind_wdata = 8'h33; step;
    chk(stack_ptr_reg, s);
    @(negedge clk);
    ind_rd = 1'b1; step;
    chk(rd_data, 16'h0033);
  endtask
  task automatic t_xdata;
    dwr(8'h83, 8'hff);
    dwr(8'h82, 8'h10);
    chk(xdata_pointer, 16'hff10);
    @(negedge clk);
    xd_wr = 1'b1; xd_use_data_pointer = 1'b1; xd_wdata = 8'ha5; step;
    @(negedge clk);
    xd_rd = 1'b1; xd_use_data_pointer = 1'b0; xd_index = 8'h10; step;
    chk(xd_rdata, aux_expect);
    chk(xd_rdata, 16'h00a5);
    dwr(8'h94, 8'h10);
    drd(8'h95, 8'ha5);
    drd(8'h94, 8'h11);
    dwr(8'h95, 8'h5c);
    drd(8'h94, 8'h12);
    @(negedge clk);
    xd_rd = 1'b1; xd_index = 8'h11; step;
    chk(xd_rdata, 16'h005c);
    @(negedge clk);
    aux_enable = 1'b0; xd_rd = 1'b1; step;
    chk(xd_rdata, 16'h0000);
    aux_enable = 1'b1;
  endtask
  task automatic end_of_test;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    #(5 * 2000);
    n_errors++;
    end_of_test;
  end
  initial begin
    op = core_map_pkg::op_none;
    alu_op = core_map_pkg::alu_add;
    {alu_use_carry, rot_left, bit_test, mul_div_wr, dir_wr, dir_rd, ind_wr, ind_rd, bank_wr, bit_wr} = '0;
    {bit_val, xd_wr, xd_rd, xd_use_data_pointer, alu_operand, bit_test_operand, dir_addr, dir_wdata} = '0;
    {ind_addr, ind_wdata, bank_wdata, bit_addr, xd_index, xd_wdata, load_pc, mul_div_pair, irq_sel, bank_reg} = '0;
    aux_enable = 1'b1;
    reset_n = 1'b0;
    repeat (16) @(negedge clk);
    reset_n = 1'b1;
    t_reset;
    t_stack;
    t_alu;
    t_space;
    t_xdata;
    end_of_test;
  end
endmodule
